/* logic/pwm_pkg.sv */
/*
 Shared constants, bus carrier and counter step function for the six-channel
 pulse-width modulator counter, period and duty logic.
 Assumes a classic Wishbone slave with one aligned 32-bit word per register.
*/
package pwm_pkg;

	localparam int         NCH        = 6;
	localparam int         NPAIR      = 3;

	// Register byte addresses, one word each
	localparam logic [7:0] CNT_BASE   = 8'h00;
	localparam logic [7:0] PER_BASE   = 8'h18;
	localparam logic [7:0] DTY_BASE   = 8'h30;
	localparam logic [7:0] TEST_A_ADR = 8'h48;
	localparam logic [7:0] TEST_B_ADR = 8'h4c;
	localparam logic [7:0] ENA_ADR    = 8'h50;
	localparam logic [7:0] POL_ADR    = 8'h54;
	localparam logic [7:0] CTR_ADR    = 8'h58;
	localparam logic [7:0] JOIN_ADR   = 8'h5c;
	localparam logic [7:0] REG_STRIDE = 8'h04;

	// Reset values
	localparam logic [7:0] CNT_RST    = 8'h00;
	localparam logic [7:0] PER_RST    = 8'h00;
	localparam logic [7:0] DTY_RST    = 8'hff;
	localparam logic [5:0] CTRL_RST   = 6'h00;
	localparam logic [2:0] JOIN_RST   = 3'h0;
	localparam logic [7:0] TEST_READ  = 8'h00;

	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	// Result of one counter step
	typedef struct packed {
		logic [15:0] cnt;
		logic        down;
		logic        wrap;
	} step_t;

	// One tick of a counter; 8-bit channels pass zero-extended values
	function automatic step_t chan_step(input logic [15:0] cnt, input logic [15:0] per,
		input logic down, input logic center);
		step_t s;
		s.cnt  = cnt + 16'h0001;
		s.down = down;
		s.wrap = 1'b0;
		if (!center) begin
			// Left aligned: 0 .. per-1, then back to 0
			if (s.cnt >= per || s.cnt == 16'h0000) begin
				s.cnt  = 16'h0000;
				s.wrap = 1'b1;
			end
		end else if (!down && cnt < per) begin
			s.cnt = cnt + 16'h0001;
		end else if (cnt <= 16'h0001) begin
			// Center aligned: back at the bottom ends the period
			s.cnt  = 16'h0000;
			s.down = 1'b0;
			s.wrap = 1'b1;
		end else begin
			s.cnt  = cnt - 16'h0001;
			s.down = 1'b1;
		end
		return s;
	endfunction

endpackage

/* logic/pwm_counter.sv */
/*
 Counter, period and duty logic of a six-channel 8-bit pulse-width modulator,
 with pairs joinable into 16-bit channels, reached over classic Wishbone.
 Assumes a prescaler in the same clock domain giving one-cycle tick pulses,
 one per channel, at the channel's selected clock rate.
*/
// The address map and register access over Wishbone were chosen for this implementation.
// Behaviour
// RL1 - Each channel has an 8-bit up/down counter stepping on its selected clock tick.
// RL2 - Reading a counter returns the count and leaves the channel undisturbed.
// RL3 - Left aligned mode counts from 0 up to period minus one.
// RL4 - Center aligned mode counts up to period, then down to zero, repeating.
// RL5 - Counter write clears count, direction up, loads buffers, output from polarity.
// RL6 - Counter clears itself when the effective period ends.
// RL7 - A disabled channel holds its counter.
// RL8 - On enable the counter resumes from the count it holds.
// RL9 - Joined pair: a write to either counter byte resets the whole 16-bit counter.
// RL10 - Software reads a joined counter with one 16-bit access for coherency; here each counter byte is its own word, read one byte at a time.
// RL11 - Software avoids counter writes while enabled; one cycle may be irregular.
// RL12 - Both scale-counter test registers read zero and ignore writes.
// RL13 - Period writes while enabled wait for period end, counter write or disable.
// RL14 - Period write while disabled updates buffer and active value together.
// RL15 - Period read returns the last written value, not necessarily the active one.
// RL16 - Output period is tick period times period, doubled in center aligned mode.
// RL17 - Output toggles whenever the counter equals the active duty.
// RL18 - Duty writes while enabled wait for period end, counter write or disable.
// RL19 - Duty write while disabled updates buffer and active value together.
// RL20 - Duty read returns the last written value, not necessarily the active one.
// RL21 - Polarity 1 starts high and falls on match; polarity 0 the reverse.
// RL22 - Joined pair: lower channel is the high byte, higher channel the low byte.
`timescale 1ns/1ps

module pwm_counter
	import pwm_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire wb_req_t           wb_req,
	input  wire logic [NCH-1:0]    chan_tick,
	output logic                   wb_ack,
	output logic [31:0]            wb_dat,
	output logic [NCH-1:0]         pwm_out
);

	// Which channel a word address selects inside a block of six
	function automatic logic [3:0] slot(input logic [7:0] adr, input logic [7:0] base);
		logic [7:0] d;
		d = adr - base;
		if (adr >= base && d < 8'(NCH * 4) && d[1:0] == 2'b00) begin
			slot = {1'b1, d[4:2]};
		end else begin
			slot = 4'h0;
		end
	endfunction

	// Byte of a 16-bit value that a channel owns
	function automatic logic [7:0] pick(input logic joined, input logic odd,
		input logic [15:0] v);
		pick = (joined && !odd) ? v[15:8] : v[7:0];
	endfunction

	logic [NCH-1:0][7:0] cnt_r;
	logic [NCH-1:0][7:0] per_buf_r;
	logic [NCH-1:0][7:0] per_act_r;
	logic [NCH-1:0][7:0] dty_buf_r;
	logic [NCH-1:0][7:0] dty_act_r;
	logic [NCH-1:0]      down_r;
	logic [NCH-1:0]      out_r;
	logic [NCH-1:0]      ena_r;
	logic [NCH-1:0]      pol_r;
	logic [NCH-1:0]      ctr_r;
	logic [NPAIR-1:0]    join_r;
	logic                ack_r;
	logic [31:0]         dat_r;
	logic [31:0]         dat_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Access taken in the cycle before ack; ack drops after one cycle
	wire        req     = wb_req.cyc && wb_req.stb && !ack_r;
	wire        wr_en   = req && wb_req.we && wb_req.sel[0];
	wire [3:0]  cnt_s   = slot(wb_req.adr, CNT_BASE);
	wire [3:0]  per_s   = slot(wb_req.adr, PER_BASE);
	wire [3:0]  dty_s   = slot(wb_req.adr, DTY_BASE);
	wire [7:0]  wdat    = wb_req.dat[7:0];
	wire        wr_ena  = wr_en && wb_req.adr == ENA_ADR;
	wire        wr_pol  = wr_en && wb_req.adr == POL_ADR;
	wire        wr_ctr  = wr_en && wb_req.adr == CTR_ADR;
	wire        wr_join = wr_en && wb_req.adr == JOIN_ADR;

	// Read mux; reads have no side effects on the counters
	always_comb begin
		dat_nxt = 32'h0000_0000;
		if (cnt_s[3]) begin
			dat_nxt[7:0] = cnt_r[cnt_s[2:0]]; // RL2
		end else if (per_s[3]) begin
			dat_nxt[7:0] = per_buf_r[per_s[2:0]]; // RL15
		end else if (dty_s[3]) begin
			dat_nxt[7:0] = dty_buf_r[dty_s[2:0]]; // RL20
		end else if (wb_req.adr == TEST_A_ADR || wb_req.adr == TEST_B_ADR) begin
			dat_nxt[7:0] = TEST_READ; // RL12
		end else if (wb_req.adr == ENA_ADR) begin
			dat_nxt[5:0] = ena_r;
		end else if (wb_req.adr == POL_ADR) begin
			dat_nxt[5:0] = pol_r;
		end else if (wb_req.adr == CTR_ADR) begin
			dat_nxt[5:0] = ctr_r;
		end else if (wb_req.adr == JOIN_ADR) begin
			dat_nxt[2:0] = join_r;
		end
	end

	// Bus answer; unmapped addresses ack with zero, test registers ignore writes
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			dat_r <= req ? dat_nxt : dat_r;
		end
	end

	// Mode and enable bits
	always_ff @(posedge clock) begin
		if (rst) begin
			ena_r  <= CTRL_RST;
			pol_r  <= CTRL_RST;
			ctr_r  <= CTRL_RST;
			join_r <= JOIN_RST;
		end else begin
			ena_r  <= wr_ena ? wdat[5:0] : ena_r;
			pol_r  <= wr_pol ? wdat[5:0] : pol_r;
			ctr_r  <= wr_ctr ? wdat[5:0] : ctr_r;
			join_r <= wr_join ? wdat[2:0] : join_r;
		end
	end

	assign wb_ack  = ack_r;
	assign wb_dat  = dat_r;
	assign pwm_out = out_r;

	////////////////////////////////////////////////////////////////////////////
	// Channels

	logic [NCH-1:0] wr_cnt;
	logic [NCH-1:0] wr_per;
	logic [NCH-1:0] wr_dty;

	for (genvar g = 0; g < NCH; g++) begin : ch
		localparam int H = g - (g % 2);
		localparam int L = H + 1;
		localparam int P = g / 2;

		assign wr_cnt[g] = wr_en && cnt_s == {1'b1, 3'(g)};
		assign wr_per[g] = wr_en && per_s == {1'b1, 3'(g)};
		assign wr_dty[g] = wr_en && dty_s == {1'b1, 3'(g)};

		// A joined pair runs on the odd channel's controls
		wire        jn      = join_r[P];
		wire        odd     = (g % 2) == 1;
		wire        lead    = !jn || odd;
		wire        en      = jn ? ena_r[L] : ena_r[g];
		wire        tick    = jn ? chan_tick[L] : chan_tick[g];
		wire        center  = jn ? ctr_r[L] : ctr_r[g];
		wire        pol     = jn ? pol_r[L] : pol_r[g];
		wire        down    = jn ? down_r[L] : down_r[g];
		wire        restart = jn ? (wr_cnt[H] || wr_cnt[L]) : wr_cnt[g]; // RL9

		// Wide views; lower channel is the high byte
		wire [15:0] cnt16   = jn ? {cnt_r[H], cnt_r[L]} : {8'h00, cnt_r[g]}; // RL22
		wire [15:0] per16   = jn ? {per_act_r[H], per_act_r[L]} : {8'h00, per_act_r[g]};
		wire [15:0] dtya16  = jn ? {dty_act_r[H], dty_act_r[L]} : {8'h00, dty_act_r[g]};
		wire [15:0] dtyb16  = jn ? {dty_buf_r[H], dty_buf_r[L]} : {8'h00, dty_buf_r[g]};
		wire step_t st      = chan_step(cnt16, per16, down, center); // RL3 RL4 RL16
		wire [15:0] dty_new = st.wrap ? dtyb16 : dtya16;
		wire        match   = st.cnt == dty_new;
		wire        out_pre = st.wrap ? pol : out_r[g];

		// Counter and direction
		always_ff @(posedge clock) begin
			if (rst) begin
				cnt_r[g]  <= CNT_RST;
				down_r[g] <= 1'b0;
			end else if (restart) begin
				cnt_r[g]  <= CNT_RST; // RL5
				down_r[g] <= 1'b0; // RL5
			end else if (en && tick) begin
				cnt_r[g]  <= pick(jn, odd, st.cnt); // RL1 RL6
				down_r[g] <= st.down;
			end
			// Disabled: count held, resumes from it on enable RL7 RL8
		end

		// Output; a tick moves only the lead channel's pin of a pair, a counter write sets both to polarity
		always_ff @(posedge clock) begin
			if (rst) begin
				out_r[g] <= 1'b0;
			end else if (restart) begin
				out_r[g] <= pol; // RL5 RL21
			end else if (en && tick && lead) begin
				out_r[g] <= out_pre ^ match; // RL17 RL21
			end
		end

		// Double-buffered period and duty
		always_ff @(posedge clock) begin
			if (rst) begin
				per_buf_r[g] <= PER_RST;
				per_act_r[g] <= PER_RST;
				dty_buf_r[g] <= DTY_RST;
				dty_act_r[g] <= DTY_RST;
			end else begin
				if (restart || !en || (tick && st.wrap)) begin
					per_act_r[g] <= per_buf_r[g]; // RL13
					dty_act_r[g] <= dty_buf_r[g]; // RL18
				end
				if (wr_per[g]) begin
					per_buf_r[g] <= wdat;
					if (!en) begin
						per_act_r[g] <= wdat; // RL14
					end
				end
				if (wr_dty[g]) begin
					dty_buf_r[g] <= wdat;
					if (!en) begin
						dty_act_r[g] <= wdat; // RL19
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks on channel 1 running as a separate 8-bit channel, and on the test register read

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	wire solo = !join_r[0];
	wire step1 = solo && ena_r[1] && chan_tick[1] && !wr_cnt[1];

	sequence cnt_write_s;
		solo && wr_cnt[1];
	endsequence

	sequence center_top_s;
		step1 && ctr_r[1] && !down_r[1] && cnt_r[1] == per_act_r[1] && cnt_r[1] > 8'h01;
	endsequence

	cnt_clear_a: assert property (cnt_write_s |=> cnt_r[1] == 8'h00 && !down_r[1]) // RL5
		else $error("counter write did not clear count and direction");
	load_on_write_a: assert property (cnt_write_s ##0 !wr_per[1] |=>
		per_act_r[1] == $past(per_buf_r[1])) // RL5
		else $error("counter write did not load period buffer");
	out_pol_a: assert property (cnt_write_s |=> pwm_out[1] == $past(pol_r[1])) // RL21
		else $error("counter write left output at wrong level");
	hold_off_a: assert property (solo && !ena_r[1] && !wr_cnt[1] |=> $stable(cnt_r[1])) // RL7
		else $error("disabled counter moved");
	left_wrap_a: assert property (step1 && !ctr_r[1] && per_act_r[1] != 8'h00 &&
		cnt_r[1] == per_act_r[1] - 8'h01 |=> cnt_r[1] == 8'h00) // RL3
		else $error("left aligned counter did not wrap at period minus one");
	center_turn_a: assert property (center_top_s |=> down_r[1] &&
		cnt_r[1] == $past(cnt_r[1]) - 8'h01) // RL4
		else $error("center aligned counter did not turn down at period");
	per_held_a: assert property (solo && ena_r[1] && !chan_tick[1] && !wr_cnt[1] &&
		wr_per[1] |=> $stable(per_act_r[1])) // RL13
		else $error("period changed mid period");
	per_direct_a: assert property (solo && !ena_r[1] && wr_per[1] |=>
		per_act_r[1] == $past(wdat) && per_buf_r[1] == $past(wdat)) // RL14
		else $error("disabled period write not direct");
	dty_direct_a: assert property (solo && !ena_r[1] && wr_dty[1] |=>
		dty_act_r[1] == $past(wdat)) // RL19
		else $error("disabled duty write not direct");
	test_zero_a: assert property (req && !wb_req.we && wb_req.adr == TEST_A_ADR |=>
		wb_ack && wb_dat == 32'h0000_0000) // RL12
		else $error("test register read not zero");
	toggle_match_a: assert property (step1 && !ctr_r[1] && // RL17
		{1'b0, cnt_r[1]} + 9'h001 < {1'b0, per_act_r[1]} &&
		cnt_r[1] + 8'h01 == dty_act_r[1] |=> pwm_out[1] != $past(pwm_out[1]))
		else $error("output did not toggle on duty match");
	read_clean_a: assert property (req && !wb_req.we && cnt_s[3] && !step1 && solo &&
		!wr_cnt[1] && !ena_r[1] |=> $stable(cnt_r[1])) // RL2
		else $error("counter read disturbed count");

	////////////////////////////////////////////////////////////////////////////
	// Further checks on bus ack, stepping, buffering, output level and the joined pair

	// Ack is a single-cycle pulse; a request still held after it is taken again one cycle later
	ack_pulse_a: assert property (wb_ack |=> !wb_ack)
		else $error("ack stayed high for two cycles");

	// Every taken request is answered on the next edge
	ack_next_a: assert property (req |=> wb_ack)
		else $error("request not answered in one cycle");

	// Left aligned step below the period end adds one
	left_step_a: assert property (step1 && !ctr_r[1] && // RL1 RL8
		{1'b0, cnt_r[1]} + 9'h001 < {1'b0, per_act_r[1]} |=>
		cnt_r[1] == $past(cnt_r[1]) + 8'h01)
		else $error("left aligned counter did not step by one");

	// Without a tick an enabled counter stands still
	idle_tick_a: assert property (solo && ena_r[1] && !chan_tick[1] && // RL1
		!wr_cnt[1] |=> $stable(cnt_r[1]))
		else $error("counter moved without a tick");

	// Center aligned rising half
	center_up_a: assert property (step1 && ctr_r[1] && !down_r[1] && // RL4
		cnt_r[1] < per_act_r[1] |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01 && !down_r[1])
		else $error("center aligned counter did not count up");

	// Center aligned period ends back at the bottom
	center_end_a: assert property (step1 && ctr_r[1] && down_r[1] && // RL4 RL6
		cnt_r[1] <= 8'h01 |=> cnt_r[1] == 8'h00 && !down_r[1])
		else $error("center aligned counter did not end at zero");

	// A disabled channel keeps its output level
	hold_out_a: assert property (solo && !ena_r[1] && !wr_cnt[1] |=> // RL7
		$stable(pwm_out[1]))
		else $error("disabled output moved");

	// Counter write also loads the duty buffer
	load_dty_write_a: assert property (cnt_write_s ##0 !wr_dty[1] |=> // RL5
		dty_act_r[1] == $past(dty_buf_r[1]))
		else $error("counter write did not load duty buffer");

	// Duty writes while running wait for the period end
	dty_held_a: assert property (solo && ena_r[1] && !chan_tick[1] && // RL18
		!wr_cnt[1] && wr_dty[1] |=> $stable(dty_act_r[1]))
		else $error("duty changed mid period");

	// Disabling a channel hands the buffered period over
	off_per_load_a: assert property (solo && !ena_r[1] && !wr_per[1] |=> // RL13
		per_act_r[1] == $past(per_buf_r[1]))
		else $error("disabled channel did not take period buffer");

	// Disabling a channel hands the buffered duty over
	off_dty_load_a: assert property (solo && !ena_r[1] && !wr_dty[1] |=> // RL18
		dty_act_r[1] == $past(dty_buf_r[1]))
		else $error("disabled channel did not take duty buffer");

	// Period end hands the buffered period over
	wrap_load_a: assert property (step1 && ch[1].st.wrap && !wr_per[1] |=> // RL13
		per_act_r[1] == $past(per_buf_r[1]))
		else $error("period end did not load period buffer");

	// Period buffer always holds the last write, read back as such
	per_buf_a: assert property (wr_per[1] |=> per_buf_r[1] == $past(wdat)) // RL15
		else $error("period buffer lost a write");

	// Duty buffer always holds the last write, read back as such
	dty_buf_a: assert property (wr_dty[1] |=> dty_buf_r[1] == $past(wdat)) // RL20
		else $error("duty buffer lost a write");

	// A new period starts at the polarity level unless the duty hits zero
	wrap_pol_a: assert property (step1 && ch[1].st.wrap && // RL21
		dty_buf_r[1] != 8'h00 |=> pwm_out[1] == $past(pol_r[1]))
		else $error("period did not start at polarity level");

	// Either byte write restarts the whole joined counter
	join_restart_a: assert property (join_r[2] && (wr_cnt[4] || wr_cnt[5]) |=> // RL9
		cnt_r[4] == 8'h00 && cnt_r[5] == 8'h00)
		else $error("joined counter not fully cleared");

	// Low byte overflow carries into the lower channel
	join_carry_a: assert property (join_r[2] && ena_r[5] && chan_tick[5] && // RL22
		!wr_cnt[4] && !wr_cnt[5] && !ctr_r[5] && cnt_r[5] == 8'hff &&
		{1'b0, cnt_r[4], cnt_r[5]} + 17'h00001 < {1'b0, per_act_r[4], per_act_r[5]} |=>
		cnt_r[4] == $past(cnt_r[4]) + 8'h01 && cnt_r[5] == 8'h00)
		else $error("joined counter did not carry into high byte");

endmodule

/* verif/pwm_counter_tb.sv */
/*
 Self-checking bench for the channel counter, period and duty logic.
 Assumes the design package and one 20 MHz clock; the bench acts as the
 Wishbone master and as the prescaler that sends the channel ticks.
*/
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module pwm_counter_tb;
	import pwm_pkg::*;

	logic           clock;
	logic           rst;
	wb_req_t        wb_req;
	logic [NCH-1:0] chan_tick;
	logic           wb_ack;
	logic [31:0]    wb_dat;
	logic [NCH-1:0] pwm_out;
	int             n_fail;
	int             n_checks;
	logic [31:0]    lfsr_r;
	logic [31:0]    q;
	logic [7:0]     m_cnt, m_per, m_dty, b_per, b_dty, per, dty;
	logic           m_down, m_out, m_pol;

	pwm_counter uut (.clock(clock), .rst(rst), .wb_req(wb_req), .chan_tick(chan_tick),
		.wb_ack(wb_ack), .wb_dat(wb_dat), .pwm_out(pwm_out));

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 50 ns period
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Fixed-seed random source, so every run repeats
	function automatic logic [7:0] rnd();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r[7:0];
	endfunction

	function automatic logic [7:0] adr(input logic [7:0] base, input int ch);
		return base + 8'(4 * ch);
	endfunction

	// Expected channel behaviour for one tick; period end reloads the buffers
	task automatic model_tick(input logic ctr);
		logic wrap;
		wrap = 1'b0;
		if (!ctr) begin
			if ({1'b0, m_cnt} + 9'h001 >= {1'b0, m_per}) begin
				m_cnt = 8'h00;
				wrap = 1'b1;
			end else m_cnt++;
		end else if (!m_down && m_cnt < m_per) m_cnt++;
		else if (m_cnt <= 8'h01) begin
			m_cnt = 8'h00;
			m_down = 1'b0;
			wrap = 1'b1;
		end else begin
			m_cnt--;
			m_down = 1'b1;
		end
		if (wrap) begin
			m_per = b_per;
			m_dty = b_dty;
			m_out = m_pol;
		end
		if (m_cnt == m_dty) m_out = ~m_out;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Classic single cycle; request held until ack is sampled, no fixed latency assumed
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		wb_req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h000000, d}};
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_dat;
		if (n >= 20) n_fail++;
		wb_req <= '0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		`CHK(q, {24'h000000, e})
	endtask

	// One prescaler pulse on one channel
	task automatic tick(input int ch);
		@(posedge clock);
		chan_tick <= 6'h01 << ch;
		@(posedge clock);
		chan_tick <= '0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under 30000 cycles
	initial begin
		repeat (30000) @(posedge clock);
		n_fail++;
		test_done();
	end

	// Main sequence
	initial begin
		n_fail = 0;
		n_checks = 0;
		lfsr_r = 32'ha00ee154;
		rst = 1'b1;
		wb_req = '0;
		chan_tick = '0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		for (int ch = 0; ch < NCH; ch++) begin
			rd_chk(adr(CNT_BASE, ch), 8'h00);
			rd_chk(adr(PER_BASE, ch), 8'h00);
			rd_chk(adr(DTY_BASE, ch), 8'hff);
		end
		// Test registers ignore writes; an unmapped place reads zero
		wb(1'b1, TEST_A_ADR, rnd());
		wb(1'b1, TEST_B_ADR, rnd());
		rd_chk(TEST_A_ADR, 8'h00);
		rd_chk(TEST_B_ADR, 8'h00);
		rd_chk(8'h60, 8'h00);
		// Every channel alone, alternating left and center aligned, random figures
		for (int ch = 0; ch < NCH; ch++) begin
			per = (rnd() % 8'h08) + 8'h01;
			dty = rnd() % (per + 8'h02);
			m_pol = lfsr_r[9];
			wb(1'b1, ENA_ADR, 8'h00);
			wb(1'b1, adr(PER_BASE, ch), per);
			wb(1'b1, adr(DTY_BASE, ch), dty);
			wb(1'b1, POL_ADR, 8'(m_pol) << ch);
			wb(1'b1, CTR_ADR, 8'(ch % 2) << ch);
			wb(1'b1, adr(CNT_BASE, ch), rnd());
			{m_cnt, m_down, m_out, m_per, m_dty, b_per, b_dty} = {8'h00, 1'b0, m_pol,
				per, dty, per, dty};
			`CHK(pwm_out[ch], m_pol)
			wb(1'b1, ENA_ADR, 8'h01 << ch);
			for (int k = 0; k < 4 * per + 4; k++) begin
				if (k == 3) begin
					b_per = (rnd() % 8'h08) + 8'h01;
					b_dty = rnd() % (b_per + 8'h02);
					wb(1'b1, adr(PER_BASE, ch), b_per);
					wb(1'b1, adr(DTY_BASE, ch), b_dty);
					rd_chk(adr(PER_BASE, ch), b_per);
					rd_chk(adr(DTY_BASE, ch), b_dty);
				end
				if (k == 5 + per) begin
					wb(1'b1, ENA_ADR, 8'h00);
					tick(ch);
					rd_chk(adr(CNT_BASE, ch), m_cnt);
					`CHK(pwm_out[ch], m_out)
					wb(1'b1, ENA_ADR, 8'h01 << ch);
					{m_per, m_dty} = {b_per, b_dty};
				end
				tick(ch);
				model_tick(1'(ch % 2));
				rd_chk(adr(CNT_BASE, ch), m_cnt);
				`CHK(pwm_out[ch], m_out)
			end
		end
		// Joined pair four and five: even channel is the high byte
		wb(1'b1, ENA_ADR, 8'h00);
		wb(1'b1, JOIN_ADR, 8'h04);
		wb(1'b1, adr(PER_BASE, 4), 8'h00);
		wb(1'b1, adr(PER_BASE, 5), 8'h05);
		wb(1'b1, adr(DTY_BASE, 4), 8'h00);
		wb(1'b1, adr(DTY_BASE, 5), 8'h02);
		wb(1'b1, POL_ADR, 8'h20);
		wb(1'b1, CTR_ADR, 8'h00);
		wb(1'b1, adr(CNT_BASE, 5), rnd());
		`CHK(pwm_out[5], 1'b1)
		wb(1'b1, ENA_ADR, 8'h20);
		repeat (3) tick(5);
		rd_chk(adr(CNT_BASE, 5), 8'h03);
		rd_chk(adr(CNT_BASE, 4), 8'h00);
		`CHK(pwm_out[5], 1'b0)
		wb(1'b1, adr(CNT_BASE, 4), rnd());
		rd_chk(adr(CNT_BASE, 5), 8'h00);
		`CHK(pwm_out[5], 1'b1)
		test_done();
	end

endmodule
